// *** inc/irc_pkg.sv ***
// Shared constants and types of the region-of-interest cropper
package irc_pkg;

    localparam int PIX_W      = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_W     = PIX_W + 2;
    localparam int STEP_BITS  = 4;

    localparam logic [15:0] WIDTH_MIN        = 16'h0030;
    localparam logic [15:0] WIDTH_MAX        = 16'h8000;
    localparam logic [15:0] WIDTH_MIRROR_MAX = 16'h5550;
    localparam logic [16:0] COL_SUM_MAX      = 17'h0_8000;
    localparam logic [15:0] COL_START_MAX    = 16'h7FD0;

    localparam logic [16:0] HEIGHT_MIN       = 17'h0_0002;
    localparam logic [16:0] HEIGHT_MAX       = 17'h1_0000;
    localparam logic [17:0] ROW_SUM_MAX      = 18'h1_0000;
    localparam logic [15:0] ROW_START_MAX    = 16'hFFFF;

    localparam logic [15:0] WIDTH_RST        = 16'h0400;
    localparam logic [16:0] HEIGHT_RST       = 17'h0_0400;
    localparam logic [15:0] COL_START_RST    = 16'h0000;
    localparam logic [15:0] ROW_START_RST    = 16'h0000;
    localparam logic [32:0] FRAME_PIX_RST    = 33'h0_0010_0000;

    // Frame store holds two frames for double buffering
    localparam logic [35:0] DRAM_PIXELS_DEF  = 36'h1_0000_0000;

    typedef enum logic {
        IRC_PASS,
        IRC_PAD
    } irc_mode_e;

endpackage

// *** inc/irc_stream_if.sv ***
// Valid/ready word stream between the cropper and its FIFO
interface irc_stream_if #(
    parameter int W = 18
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// *** src/irc_crop.sv ***
// Region-of-interest cropper: settings check, window cut, line padding, output FIFO
//
// Summary of operation
// - Width 48 to 32768, step 16, reset 1024
// - Width plus column start at most 32768
// - Mirrored width limited to 21840 pixels
// - Mirrored width plus start within full frame
// - Both mirrors: double frame must fit DRAM
// - Height 2 to 65536, step 1, reset 1024
// - Height plus row start at most 65536
// - Vertical mirror caps rows at full frame
// - Frame size bounded by DRAM capacity
// - Column start 0 to 32720, step 16
// - Row start 0 to 65535, reset zero
// - Crop size sets and reports DMA size
// - Settings refused while acquisition runs
// - Short camera lines padded to full width
module irc_crop #(
    parameter logic [35:0] DRAM_PIXELS = irc_pkg::DRAM_PIXELS_DEF
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic                      acqRun,
    input  wire logic                      cfgWrite,
    input  wire logic [15:0]               cfgWidth,
    input  wire logic [16:0]               cfgHeight,
    input  wire logic [15:0]               cfgColStart,
    input  wire logic [15:0]               cfgRowStart,
    input  wire logic                      hMirror,
    input  wire logic                      vMirror,
    input  wire logic [15:0]               fullFrameCols,
    input  wire logic [16:0]               fullFrameRows,
    output logic                           cfgAccept,
    output logic                           cfgReject,
    output logic [15:0]                    imgWidth,
    output logic [16:0]                    imgHeight,
    output logic [32:0]                    dmaFramePixels,
    input  wire logic                      inValid,
    output logic                           inReady,
    input  wire logic [irc_pkg::PIX_W-1:0] inData,
    input  wire logic                      inFrameStart,
    input  wire logic                      inLineEnd,
    output logic                           outValid,
    input  wire logic                      outReady,
    output logic [irc_pkg::PIX_W-1:0]      outData,
    output logic                           outLineEnd,
    output logic                           outFrameEnd
);
    import irc_pkg::*;

    typedef struct packed {
        irc_mode_e   mode;
        logic [15:0] width;
        logic [16:0] height;
        logic [15:0] colStart;
        logic [15:0] rowStart;
        logic [32:0] framePixels;
        logic        accept;
        logic        reject;
        logic [15:0] col;
        logic [16:0] row;
        logic [15:0] emitted;
        logic        lineDone;
        logic        padFrameEnd;
    } irc_crop_state_s;

    irc_crop_state_s s;
    irc_crop_state_s next_s;

    irc_stream_if #(.W(FIFO_W)) pushBus ();
    irc_stream_if #(.W(FIFO_W)) popBus ();

    ////////////////////////////////////////////////////////////////////////////////////
    // Settings check
    logic [16:0] sumW;
    logic [15:0] maxW;
    logic [17:0] sumH;
    logic [17:0] maxH;
    logic [16:0] frameCols;
    logic [17:0] frameRows;
    logic [34:0] frameProd;
    logic [35:0] frameNeed;
    logic        widthOk;
    logic        heightOk;
    logic        colStartOk;
    logic        rowStartOk;
    logic        colSumOk;
    logic        rowSumOk;
    logic        dramOk;
    logic        cfgOk;

    assign widthOk    = (cfgWidth >= WIDTH_MIN) && (cfgWidth <= WIDTH_MAX)
                        && (cfgWidth[STEP_BITS-1:0] == '0);
    assign heightOk   = (cfgHeight >= HEIGHT_MIN) && (cfgHeight <= HEIGHT_MAX);
    assign colStartOk = (cfgColStart <= COL_START_MAX)
                        && (cfgColStart[STEP_BITS-1:0] == '0);
    assign rowStartOk = (cfgRowStart <= ROW_START_MAX);

    assign sumW = 17'(cfgWidth) + 17'(cfgColStart);
    // Line buffer for mirroring is shorter than a full line
    assign maxW = !hMirror ? WIDTH_MAX :
                  (fullFrameCols < WIDTH_MIRROR_MAX) ? fullFrameCols : WIDTH_MIRROR_MAX;
    assign colSumOk = (sumW <= COL_SUM_MAX) && (sumW <= {1'b0, maxW});

    assign sumH = 18'(cfgHeight) + 18'(cfgRowStart);
    assign maxH = vMirror ? {1'b0, fullFrameRows} : ROW_SUM_MAX;
    assign rowSumOk = (sumH <= ROW_SUM_MAX) && (sumH <= maxH);

    // Stored frame is the full frame along a mirrored axis, start plus cut size otherwise
    assign frameCols = hMirror ? {1'b0, fullFrameCols} : sumW;
    assign frameRows = vMirror ? {1'b0, fullFrameRows} : sumH;
    assign frameProd = 35'(frameCols) * 35'(frameRows);
    assign frameNeed = {frameProd, 1'b0};
    assign dramOk    = (frameNeed <= DRAM_PIXELS);

    assign cfgOk = widthOk && heightOk && colStartOk && rowStartOk
                   && colSumOk && rowSumOk && dramOk;

    ////////////////////////////////////////////////////////////////////////////////////
    // Window tracking
    logic [15:0] colNow;
    logic [16:0] rowNow;
    logic [15:0] emittedNow;
    logic        lineDoneNow;
    logic [16:0] colEnd;
    logic [17:0] rowEnd;
    logic        inH;
    logic        inV;
    logic        lastCol;
    logic        lastRow;
    logic        inFire;
    logic        pushFire;
    logic        padLast;
    logic        shortLine;

    // A frame start restarts counting on the same beat
    assign colNow      = inFrameStart ? '0 : s.col;
    assign rowNow      = inFrameStart ? '0 : s.row;
    assign emittedNow  = inFrameStart ? '0 : s.emitted;
    assign lineDoneNow = inFrameStart ? 1'b0 : s.lineDone;

    assign colEnd  = 17'(s.colStart) + 17'(s.width);
    assign rowEnd  = 18'(s.rowStart) + 18'(s.height);
    assign inH     = (colNow >= s.colStart) && ({1'b0, colNow} < colEnd);
    assign inV     = ({1'b0, rowNow} >= 18'(s.rowStart))
                     && ({1'b0, rowNow} < rowEnd);
    assign lastCol = ({1'b0, colNow} == colEnd - 17'h0_0001);
    assign lastRow = ({1'b0, rowNow} == rowEnd - 18'h0_0001);

    // Input stalls while padding or while the FIFO is full
    assign inReady  = (s.mode == IRC_PASS) && pushBus.ready;
    assign inFire   = inValid && inReady;
    assign padLast  = (s.emitted == s.width - 16'h0001);
    assign pushFire = pushBus.valid && pushBus.ready;
    assign shortLine = inFire && inLineEnd && inV && !lineDoneNow && !(inH && lastCol);

    always_comb begin
        if (s.mode == IRC_PAD) begin
            pushBus.valid = 1'b1;
            pushBus.data  = {s.padFrameEnd && padLast, padLast, {PIX_W{1'b0}}};
        end else begin
            pushBus.valid = inFire && inH && inV;
            pushBus.data  = {lastCol && lastRow, lastCol, inData};
        end
    end

    assign popBus.ready = outReady;

    irc_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pushSide (pushBus),
        .popSide  (popBus)
    );

    ////////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s        = s;
        next_s.accept = 1'b0;
        next_s.reject = 1'b0;

        // Changing the cut mid-stream would tear frames
        if (cfgWrite) begin
            if (!acqRun && cfgOk) begin
                next_s.width       = cfgWidth;
                next_s.height      = cfgHeight;
                next_s.colStart    = cfgColStart;
                next_s.rowStart    = cfgRowStart;
                next_s.framePixels = 33'(cfgWidth) * 33'(cfgHeight);
                next_s.accept      = 1'b1;
            end else begin
                next_s.reject      = 1'b1;
            end
        end

        case (s.mode)
            IRC_PASS: begin
                if (inFire) begin
                    next_s.emitted  = emittedNow + 16'(pushFire);
                    next_s.lineDone = lineDoneNow || (pushFire && lastCol);
                    next_s.col      = colNow + 16'h0001;
                    next_s.row      = rowNow;
                    if (inLineEnd) begin
                        next_s.col      = '0;
                        next_s.row      = rowNow + 17'h0_0001;
                        next_s.emitted  = '0;
                        next_s.lineDone = 1'b0;
                    end
                    if (shortLine) begin
                        next_s.mode        = IRC_PAD;
                        next_s.emitted     = emittedNow + 16'(pushFire);
                        next_s.padFrameEnd = lastRow;
                    end
                end
            end
            IRC_PAD: begin
                if (pushBus.ready) begin
                    next_s.emitted = s.emitted + 16'h0001;
                    if (padLast) begin
                        next_s.mode    = IRC_PASS;
                        next_s.emitted = '0;
                    end
                end
            end
            default: begin
                next_s.mode = IRC_PASS;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s             <= '0;
            s.mode        <= IRC_PASS;
            s.width       <= WIDTH_RST;
            s.height      <= HEIGHT_RST;
            s.colStart    <= COL_START_RST;
            s.rowStart    <= ROW_START_RST;
            s.framePixels <= FRAME_PIX_RST;
        end else begin
            s <= next_s;
        end
    end

    assign cfgAccept      = s.accept;
    assign cfgReject      = s.reject;
    assign imgWidth       = s.width;
    assign imgHeight      = s.height;
    assign dmaFramePixels = s.framePixels;
    assign outValid       = popBus.valid;
    assign outData        = popBus.data[PIX_W-1:0];
    assign outLineEnd     = popBus.data[PIX_W];
    assign outFrameEnd    = popBus.data[PIX_W+1];

    ////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_width_range;
        cfgAccept |-> imgWidth >= WIDTH_MIN && imgWidth <= WIDTH_MAX
                      && imgWidth[STEP_BITS-1:0] == '0;
    endproperty
    a_width_range: assert property (p_width_range) else $error("Bad width taken");

    property p_col_sum;
        cfgAccept |-> 17'(imgWidth) + 17'(s.colStart) <= COL_SUM_MAX
                      && s.colStart <= COL_START_MAX && s.colStart[STEP_BITS-1:0] == '0;
    endproperty
    a_col_sum: assert property (p_col_sum) else $error("Column span too wide");

    property p_mirror_width;
        cfgAccept && $past(hMirror) |->
            17'(imgWidth) + 17'(s.colStart) <= 17'(WIDTH_MIRROR_MAX)
            && 17'(imgWidth) + 17'(s.colStart) <= 17'($past(fullFrameCols));
    endproperty
    a_mirror_width: assert property (p_mirror_width) else $error("Mirror width limit broken");

    property p_dram_fit;
        cfgAccept |-> $past(frameNeed) <= DRAM_PIXELS;
    endproperty
    a_dram_fit: assert property (p_dram_fit) else $error("Frame does not fit DRAM");

    property p_height_range;
        cfgAccept |-> imgHeight >= HEIGHT_MIN
                      && 18'(imgHeight) + 18'(s.rowStart) <= ROW_SUM_MAX;
    endproperty
    a_height_range: assert property (p_height_range) else $error("Bad height taken");

    property p_vmirror_height;
        cfgAccept && $past(vMirror) |->
            18'(imgHeight) + 18'(s.rowStart) <= 18'($past(fullFrameRows));
    endproperty
    a_vmirror_height: assert property (p_vmirror_height) else $error("Row span past frame");

    property p_dma_size;
        cfgAccept |-> dmaFramePixels == 33'(imgWidth) * 33'(imgHeight);
    endproperty
    a_dma_size: assert property (p_dma_size) else $error("DMA size mismatch");

    sequence s_run_write;
        cfgWrite && acqRun;
    endsequence
    sequence s_refused;
        cfgReject && !cfgAccept && $stable(imgWidth) && $stable(imgHeight);
    endsequence
    property p_run_refuse;
        s_run_write |=> s_refused;
    endproperty
    a_run_refuse: assert property (p_run_refuse) else $error("Write taken while running");

    property p_pad_stall;
        s.mode == IRC_PAD |-> !inReady && pushBus.valid && pushBus.data[PIX_W-1:0] == '0;
    endproperty
    a_pad_stall: assert property (p_pad_stall) else $error("Padding not stalling input");

    sequence s_pad_last;
        s.mode == IRC_PAD && pushBus.ready && padLast;
    endsequence
    property p_pad_exit;
        s_pad_last |-> pushBus.data[PIX_W] ##1 s.mode == IRC_PASS && s.emitted == '0;
    endproperty
    a_pad_exit: assert property (p_pad_exit) else $error("Padding did not end line");

    property p_window;
        s.mode == IRC_PASS && pushBus.valid |-> inFire
            && 32'(colNow) - 32'(s.colStart) < 32'(s.width)
            && 32'(rowNow) - 32'(s.rowStart) < 32'(s.height);
    endproperty
    a_window: assert property (p_window) else $error("Pixel outside window pushed");

    property p_accept_idle;
        cfgAccept |-> $past(cfgWrite) && !$past(acqRun) && !cfgReject;
    endproperty
    a_accept_idle: assert property (p_accept_idle) else $error("Write taken while busy");

    property p_frame_end;
        outValid && outFrameEnd |-> outLineEnd;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("Frame end off a line end");
endmodule

// *** src/irc_fifo.sv ***
// Parameterised FIFO with registered read data
module irc_fifo #(
    parameter int W     = 18,
    parameter int DEPTH = 32
) (
    input wire logic    sys_clk,
    input wire logic    rst_n,
    irc_stream_if.snk   pushSide,
    irc_stream_if.src   popSide
);
    import irc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wrPtr;
        logic [AW-1:0]           rdPtr;
        logic [AW:0]             count;
        logic                    outValid;
        logic [W-1:0]            outData;
    } irc_fifo_state_s;

    irc_fifo_state_s s;
    irc_fifo_state_s next_s;
    logic            pushFire;
    logic            popFire;
    logic            load;

    assign pushSide.ready = (s.count < (AW+1)'(DEPTH));
    assign pushFire       = pushSide.valid && pushSide.ready;
    assign popFire        = s.outValid && popSide.ready;
    // Refill the output register whenever it empties or is taken
    assign load           = (s.count != '0) && (!s.outValid || popFire);
    assign popSide.valid  = s.outValid;
    assign popSide.data   = s.outData;

    always_comb begin
        next_s = s;
        if (pushFire) begin
            next_s.mem[s.wrPtr] = pushSide.data;
            next_s.wrPtr        = s.wrPtr + AW'(1);
        end
        if (load) begin
            next_s.outData  = s.mem[s.rdPtr];
            next_s.rdPtr    = s.rdPtr + AW'(1);
            next_s.outValid = 1'b1;
        end else if (popFire) begin
            next_s.outValid = 1'b0;
        end
        next_s.count = s.count + (AW+1)'(pushFire) - (AW+1)'(load);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    property p_fifo_bound;
        @(posedge sys_clk) disable iff (!rst_n)
        s.count <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("FIFO count above depth");

    property p_fifo_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        popSide.valid && !popSide.ready |=> popSide.valid && $stable(popSide.data);
    endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("FIFO output dropped unread");
endmodule

// *** tb/irc_cam_model.sv ***
// Camera pixel source and DMA sink facing the cropper
module irc_cam_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [15:0] cols,
    input  wire logic [15:0] rows,
    input  wire logic        gap,
    input  wire logic [1:0]  sinkMode,
    input  wire logic        inReady,
    output logic             inValid,
    output logic [15:0]      inData,
    output logic             inFrameStart,
    output logic             inLineEnd,
    output logic             outReady,
    output logic             busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] col;
    logic [15:0] row;
    logic [15:0] nCol;
    logic [15:0] nRow;
    logic [3:0]  tick;
    logic        lastBeat;

    assign nCol         = (col == cols - 16'h0001) ? 16'h0000 : col + 16'h0001;
    assign nRow         = (col == cols - 16'h0001) ? row + 16'h0001 : row;
    assign lastBeat     = (col == cols - 16'h0001) && (row == rows - 16'h0001);
    assign inFrameStart = inValid && (col == 16'h0000) && (row == 16'h0000);
    assign inLineEnd    = inValid && (col == cols - 16'h0001);

    ////////////////////////////////////////////////////////////////////////////////
    // Beat held until taken; idle data inverted so no stale value looks valid
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy    <= 1'b0;
            inValid <= 1'b0;
            col     <= 16'h0000;
            row     <= 16'h0000;
            inData  <= 16'hA5A5;
        end else if (start && !busy) begin
            busy    <= 1'b1;
            inValid <= 1'b1;
            col     <= 16'h0000;
            row     <= 16'h0000;
            inData  <= 16'h0000;
        end else if (inValid && inReady) begin
            if (lastBeat) begin
                busy    <= 1'b0;
                inValid <= 1'b0;
                inData  <= ~inData;
            end else begin
                col     <= nCol;
                row     <= nRow;
                inValid <= !gap;
                inData  <= gap ? ~{nRow[7:0], nCol[7:0]} : {nRow[7:0], nCol[7:0]};
            end
        end else if (busy && !inValid) begin
            inValid <= 1'b1;
            inData  <= {row[7:0], col[7:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sink: 0 always ready, 1 stalled, 2 slow
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick     <= 4'h0;
            outReady <= 1'b0;
        end else begin
            tick     <= tick + 4'h1;
            outReady <= (sinkMode == 2'h0) || ((sinkMode == 2'h2) && tick[1]);
        end
    end
endmodule

// *** tb/irc_crop_test.sv ***
// Self-checking bench of the region-of-interest cropper
module irc_crop_test;
    timeunit 1ns;
    timeprecision 100ps;
    import irc_pkg::*;

    localparam int RW = 48;
    localparam int RH = 2;
    localparam int CS = 16;
    localparam int RS = 1;

    logic sys_clk, rst_n, acqRun, cfgWrite, hMirror, vMirror, cfgAccept, cfgReject;
    logic [15:0] cfgWidth, cfgColStart, cfgRowStart, fullFrameCols, imgWidth;
    logic [16:0] cfgHeight, fullFrameRows, imgHeight;
    logic [32:0] dmaFramePixels;
    logic inValid, inReady, inFrameStart, inLineEnd, outValid, outReady, outLineEnd;
    logic outFrameEnd, camStart, camGap, camBusy, sawFull;
    logic [PIX_W-1:0] inData, outData;
    logic [15:0] camCols, camRows;
    logic [1:0]  sinkMode;
    logic [17:0] expQ[$];
    int mismatches, compares, eW, eH;

    irc_crop #(.DRAM_PIXELS(36'h0_0100_0000)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .acqRun(acqRun), .cfgWrite(cfgWrite),
        .cfgWidth(cfgWidth), .cfgHeight(cfgHeight), .cfgColStart(cfgColStart),
        .cfgRowStart(cfgRowStart), .hMirror(hMirror), .vMirror(vMirror),
        .fullFrameCols(fullFrameCols), .fullFrameRows(fullFrameRows),
        .cfgAccept(cfgAccept), .cfgReject(cfgReject), .imgWidth(imgWidth),
        .imgHeight(imgHeight), .dmaFramePixels(dmaFramePixels), .inValid(inValid),
        .inReady(inReady), .inData(inData), .inFrameStart(inFrameStart),
        .inLineEnd(inLineEnd), .outValid(outValid), .outReady(outReady),
        .outData(outData), .outLineEnd(outLineEnd), .outFrameEnd(outFrameEnd));

    irc_cam_model cam (
        .sys_clk(sys_clk), .rst_n(rst_n), .start(camStart), .cols(camCols),
        .rows(camRows), .gap(camGap), .sinkMode(sinkMode), .inReady(inReady),
        .inValid(inValid), .inData(inData), .inFrameStart(inFrameStart),
        .inLineEnd(inLineEnd), .outReady(outReady), .busy(camBusy));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One settings write; a refused write must leave the image size alone
    task automatic wr(input logic [15:0] w, input logic [16:0] h, input logic [15:0] cs,
                      input logic [15:0] rs, input logic hm, input logic vm,
                      input logic [15:0] fc, input logic [16:0] fr, input logic acc);
        @(posedge sys_clk);
        cfgWrite      <= 1'b1;
        cfgWidth      <= w;
        cfgHeight     <= h;
        cfgColStart   <= cs;
        cfgRowStart   <= rs;
        hMirror       <= hm;
        vMirror       <= vm;
        fullFrameCols <= fc;
        fullFrameRows <= fr;
        @(posedge sys_clk);
        cfgWrite <= 1'b0;
        #1;
        if (acc) begin
            eW = int'(w);
            eH = int'(h);
        end
        check(cfgAccept, acc);
        check(cfgReject, !acc);
        check(imgWidth, eW[15:0]);
        check(imgHeight, eH[16:0]);
        check(dmaFramePixels, 33'(longint'(eW) * eH));
    endtask

    // One camera frame; expected words built from the window and line padding
    task automatic frame(input int c, input int r, input logic [1:0] mode, input logic g);
        int n;
        for (int rr = RS; rr < RS + RH; rr++) begin
            for (int cc = CS; cc < CS + RW; cc++) begin
                expQ.push_back({(cc < c) ? {rr[7:0], cc[7:0]} : 16'h0000,
                                cc == CS + RW - 1, (cc == CS + RW - 1) && (rr == RS + RH - 1)});
            end
        end
        @(posedge sys_clk);
        camCols  <= c[15:0];
        camRows  <= r[15:0];
        camGap   <= g;
        sinkMode <= mode;
        camStart <= 1'b1;
        @(posedge sys_clk);
        camStart <= 1'b0;
        n = 0;
        if (mode == 2'h1) begin
            while (!sawFull && n < 2000) begin
                @(posedge sys_clk);
                n++;
            end
            check(sawFull, 1'b1);
            sinkMode <= 2'h2;
        end
        while ((expQ.size() != 0 || camBusy) && n < 8000) begin
            @(posedge sys_clk);
            n++;
        end
        check(expQ.size(), 0);
        check(camBusy, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            sawFull <= 1'b0;
        end else if (inValid && !inReady) begin
            sawFull <= 1'b1;
        end
        if (rst_n && outValid && outReady) begin
            if (expQ.size() == 0) begin
                check(1'b1, 1'b0);
            end else begin
                check({outData, outLineEnd, outFrameEnd}, expQ.pop_front());
            end
        end
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        final_report();
    end

    initial begin
        {rst_n, acqRun, cfgWrite, hMirror, vMirror, camStart, camGap} = 7'h00;
        {cfgWidth, cfgColStart, cfgRowStart, fullFrameCols} = 64'h0;
        {cfgHeight, fullFrameRows} = 34'h0;
        {camCols, camRows, sinkMode} = 34'h0;
        {mismatches, compares, eW, eH} = {32'h0, 32'h0, 32'h400, 32'h400};
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        check(imgWidth, 16'h0400);
        check(imgHeight, 17'h0_0400);
        check(dmaFramePixels, 33'h0_0010_0000);
        wr(16'h0030, 17'h0_0002, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 1);
        wr(16'h0020, 17'h0_0002, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 0);
        wr(16'h0038, 17'h0_0002, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 0);
        wr(16'h8010, 17'h0_0002, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 0);
        wr(16'h8000, 17'h0_0002, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 1);
        wr(16'h0030, 17'h0_0002, 16'h7FD0, 16'h0000, 0, 0, 16'h0, 17'h0, 1);
        wr(16'h0040, 17'h0_0002, 16'h7FD0, 16'h0000, 0, 0, 16'h0, 17'h0, 0);
        wr(16'h0030, 17'h0_0002, 16'h7FE0, 16'h0000, 0, 0, 16'h0, 17'h0, 0);
        wr(16'h0030, 17'h0_0002, 16'h0008, 16'h0000, 0, 0, 16'h0, 17'h0, 0);
        wr(16'h0030, 17'h0_0001, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 0);
        wr(16'h0030, 17'h1_0000, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 1);
        wr(16'h0030, 17'h1_0001, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 0);
        wr(16'h0030, 17'h0_0002, 16'h0000, 16'hFFFE, 0, 0, 16'h0, 17'h0, 1);
        wr(16'h0030, 17'h0_0002, 16'h0000, 16'hFFFF, 0, 0, 16'h0, 17'h0, 0);
        wr(16'h5550, 17'h0_0002, 16'h0000, 16'h0000, 1, 0, 16'h8000, 17'h0, 1);
        wr(16'h5560, 17'h0_0002, 16'h0000, 16'h0000, 1, 0, 16'h8000, 17'h0, 0);
        wr(16'h03F0, 17'h0_0002, 16'h0010, 16'h0000, 1, 0, 16'h0400, 17'h0, 1);
        wr(16'h03F0, 17'h0_0002, 16'h0020, 16'h0000, 1, 0, 16'h0400, 17'h0, 0);
        wr(16'h0030, 17'h0_003C, 16'h0000, 16'h0028, 0, 1, 16'h0, 17'h0_0064, 1);
        wr(16'h0030, 17'h0_003C, 16'h0000, 16'h0029, 0, 1, 16'h0, 17'h0_0064, 0);
        wr(16'h0080, 17'h0_0002, 16'h0000, 16'h0000, 0, 1, 16'h0, 17'h1_0000, 1);
        wr(16'h0090, 17'h0_0002, 16'h0000, 16'h0000, 0, 1, 16'h0, 17'h1_0000, 0);
        wr(16'h8000, 17'h0_0100, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 1);
        wr(16'h8000, 17'h0_0101, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 0);
        wr(16'h0030, 17'h0_0002, 16'h0000, 16'h0000, 1, 1, 16'h0100, 17'h0_8000, 1);
        wr(16'h0030, 17'h0_0002, 16'h0000, 16'h0000, 1, 1, 16'h0100, 17'h0_8001, 0);
        wr(16'h0030, 17'h0_0002, 16'h0010, 16'h0001, 0, 0, 16'h0, 17'h0, 1);
        @(posedge sys_clk);
        acqRun <= 1'b1;
        wr(16'h0040, 17'h0_0004, 16'h0000, 16'h0000, 0, 0, 16'h0, 17'h0, 0);
        frame(80, 4, 2'h1, 1'b0);
        frame(32, 3, 2'h0, 1'b1);
        frame(64, 3, 2'h2, 1'b0);
        final_report();
    end
endmodule
